// ---- logic/modem_host_port_buffer.sv ----
`timescale 1ns/1ns
module modem_host_port_buffer (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic port_enable,
	input wire logic panel_bypass,
	input wire logic wide_bus,
	input wire logic port_cs,
	input wire logic port_rd,
	input wire logic port_wr,
	input wire logic [1:0] port_addr,
	input wire logic [15:0] port_data_in,
	output logic [15:0] port_data_out,
	output logic port_data_oe_n,
	output logic port_irq,
	output logic port_wait,
	input wire host_port_pkg::reg_req_t reg_req,
	output logic [15:0] reg_rdata,
	input wire host_port_pkg::mem_req_t mem_req,
	output logic [7:0] mem_rdata,
	output logic modem_irq,
	output logic [15:0] panel_wdata,
	output logic panel_sel,
	output logic panel_wr,
	output logic panel_reg_select
);
	typedef enum logic [1:0] {P_IDLE, P_WR, P_HOLD, P_RD} port_state_t;
	localparam int WR_TAKE_CYC = host_port_pkg::WR_TAKE_CYC;

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_q1_r;
	logic rst_n;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_q1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_n <= rst_q1_r;
		end
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic [15:0] len_init_r;
	logic [15:0] start_init_r;
	logic [15:0] live_ofs_r;
	logic [15:0] remain_r;
	logic armed_r;
	port_state_t state_r;
	port_state_t state_nxt;
	host_port_pkg::port_target_t tgt_r;
	logic [15:0] data_out_r;
	logic oe_n_r;
	logic [15:0] reg_rdata_r;
	logic [7:0] mem_rdata_r;
	logic [7:0] buf_r [0:host_port_pkg::BUF_BYTES-1];
	logic [15:0] panel_wdata_r;
	logic panel_sel_r;
	logic panel_wr_r;
	logic panel_rs_r;

	function automatic logic [15:0] merge_half(input logic [15:0] old, input logic [15:0] d,
		input logic wide, input logic hi);
		if (wide) begin
			merge_half = d;
		end else if (hi) begin
			merge_half = {d[7:0], old[7:0]};
		end else begin
			merge_half = {old[15:8], d[7:0]};
		end
	endfunction

	// ---------------------------------------------------------------
	// Strobe decode
	// ---------------------------------------------------------------
	wire pol = ctrl_r[host_port_pkg::CTL_POLARITY];
	wire port_live = port_enable && !panel_bypass;
	wire cs_act = port_cs ~^ pol;
	wire wr_act = port_wr ~^ pol;
	wire rd_act = port_rd ~^ pol;
	wire wr_go = port_live && cs_act && wr_act;
	wire rd_go = port_live && cs_act && rd_act && !wr_act;
	// A write is taken on its second active clock, so data has settled.
	wire wr_take = (state_r == P_WR) && wr_go;
	wire rd_start = (state_r == P_IDLE) && !wr_go && rd_go;
	wire rd_end = (state_r == P_RD) && !rd_go;
	wire [1:0] cur_tgt = (state_r == P_RD) ? tgt_r : port_addr;
	wire live_sel = ctrl_r[host_port_pkg::CTL_LIVE_SEL];
	wire init_hi = live_sel ? ctrl_r[host_port_pkg::CTL_CNT_HI] : ctrl_r[host_port_pkg::CTL_OFS_HI];
	wire [15:0] step = wide_bus ? host_port_pkg::STEP_WIDE : host_port_pkg::STEP_NARROW;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			P_IDLE: begin
				if (wr_go) begin
					state_nxt = P_WR;
				end else if (rd_go) begin
					state_nxt = P_RD;
				end
			end
			P_WR: state_nxt = wr_go ? P_HOLD : P_IDLE;
			P_HOLD: state_nxt = wr_go ? P_HOLD : P_IDLE;
			P_RD: state_nxt = rd_go ? P_RD : P_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// Access targets
	// ---------------------------------------------------------------
	wire m_ctrl_wr = wr_take && (port_addr == host_port_pkg::TGT_CTRL);
	wire m_init_wr = wr_take && (port_addr == host_port_pkg::TGT_INIT);
	wire m_buf_wr = wr_take && port_addr[1];
	wire acc_burst = (cur_tgt == host_port_pkg::TGT_BURST) && (wr_take || rd_end);
	wire c_wr = reg_req.sel && reg_req.wr;
	wire c_ctrl_wr = c_wr && (reg_req.addr == host_port_pkg::OFS_CTRL);
	wire c_len_wr = c_wr && (reg_req.addr == host_port_pkg::OFS_LEN_INIT);
	wire c_start_wr = c_wr && (reg_req.addr == host_port_pkg::OFS_START_INIT);
	wire init_load = c_len_wr || c_start_wr || m_init_wr;

	// Until the first burst after a load, accesses use the init values.
	wire [15:0] off_use = armed_r ? start_init_r : live_ofs_r;
	wire [15:0] cnt_use = armed_r ? len_init_r : remain_r;
	wire [10:0] idx = off_use[10:0];
	wire [10:0] idx_lo = {idx[10:1], 1'b0};
	wire [10:0] idx_hi = {idx[10:1], 1'b1};

	// Processors write bits 4..2 and the modem bits 5, 2, 1, 0; the modem wins bit 2.
	wire [7:0] ctrl_cpu = c_ctrl_wr ?
		((ctrl_r & ~host_port_pkg::CTRL_CPU_MASK) |
		(reg_req.wdata[7:0] & host_port_pkg::CTRL_CPU_MASK)) :
		ctrl_r;
	wire [7:0] ctrl_nxt = m_ctrl_wr ?
		((ctrl_cpu & ~host_port_pkg::CTRL_MODEM_MASK) |
		(port_data_in[7:0] & host_port_pkg::CTRL_MODEM_MASK)) :
		ctrl_cpu;

	wire [15:0] live_pick = live_sel ? remain_r : live_ofs_r;
	wire [15:0] init_rd = wide_bus ? live_pick :
		{8'h00, init_hi ? live_pick[15:8] : live_pick[7:0]};
	wire [15:0] buf_rd = wide_bus ? {buf_r[idx_hi], buf_r[idx_lo]} : {8'h00, buf_r[idx]};
	wire [15:0] modem_rd = (port_addr == host_port_pkg::TGT_CTRL) ? {8'h00, ctrl_r} :
		(port_addr == host_port_pkg::TGT_INIT) ? init_rd : buf_rd;

	// ---------------------------------------------------------------
	// Write buffer toward the memory
	// ---------------------------------------------------------------
	host_port_pkg::buf_wr_t fifo_in;
	host_port_pkg::buf_wr_t fifo_out;
	logic fifo_in_ready;
	logic fifo_out_valid;
	wire cpu_mem_wr = mem_req.sel && mem_req.wr;
	wire drain = fifo_out_valid && !cpu_mem_wr;
	assign fifo_in = '{offset: idx, data: port_data_in, wide: wide_bus};

	stream_fifo #(
		.WIDTH($bits(host_port_pkg::buf_wr_t)),
		.DEPTH(host_port_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(m_buf_wr),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(!cpu_mem_wr),
		.out_data(fifo_out)
	);

	// A write taken while the buffer is full is dropped; the modem must obey port_wait.
	assign port_wait = !fifo_in_ready;

	// ---------------------------------------------------------------
	// Dual-port memory
	// ---------------------------------------------------------------
	wire [10:0] d_lo = {fifo_out.offset[10:1], 1'b0};
	wire [10:0] d_hi = {fifo_out.offset[10:1], 1'b1};

	always_ff @(posedge ref_clk) begin
		if (cpu_mem_wr) begin
			buf_r[mem_req.addr] <= mem_req.wdata;
		end else if (drain && fifo_out.wide) begin
			buf_r[d_lo] <= fifo_out.data[7:0];
			buf_r[d_hi] <= fifo_out.data[15:8];
		end else if (drain) begin
			buf_r[fifo_out.offset] <= fifo_out.data[7:0];
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	wire [15:0] len_nxt = m_init_wr && live_sel ?
		merge_half(len_init_r, port_data_in, wide_bus, init_hi) :
		c_len_wr ? reg_req.wdata : len_init_r;
	wire [15:0] start_nxt = m_init_wr && !live_sel ?
		merge_half(start_init_r, port_data_in, wide_bus, init_hi) :
		c_start_wr ? reg_req.wdata : start_init_r;
	wire [15:0] remain_step = (cnt_use > step) ? (cnt_use - step) : 16'h0000;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= host_port_pkg::CTRL_RESET;
			len_init_r <= host_port_pkg::INIT_RESET;
			start_init_r <= host_port_pkg::INIT_RESET;
			live_ofs_r <= host_port_pkg::INIT_RESET;
			remain_r <= host_port_pkg::INIT_RESET;
			armed_r <= 1'b1;
		end else begin
			ctrl_r <= ctrl_nxt;
			len_init_r <= len_nxt;
			start_init_r <= start_nxt;
			if (acc_burst) begin
				live_ofs_r <= off_use + step;
				remain_r <= remain_step;
			end
			armed_r <= init_load || (armed_r && !acc_burst);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= P_IDLE;
			tgt_r <= host_port_pkg::TGT_CTRL;
			data_out_r <= 16'h0000;
			oe_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			if (rd_start) begin
				tgt_r <= host_port_pkg::port_target_t'(port_addr);
				data_out_r <= modem_rd;
			end
			oe_n_r <= (state_nxt != P_RD);
		end
	end

	// ---------------------------------------------------------------
	// Processor reads and panel bypass
	// ---------------------------------------------------------------
	wire [15:0] reg_rd = (reg_req.addr == host_port_pkg::OFS_CTRL) ? {8'h00, ctrl_r} :
		(reg_req.addr == host_port_pkg::OFS_LEN_INIT) ? len_init_r :
		(reg_req.addr == host_port_pkg::OFS_START_INIT) ? start_init_r :
		(reg_req.addr == host_port_pkg::OFS_LIVE_OFS) ? live_ofs_r :
		(reg_req.addr == host_port_pkg::OFS_REMAIN) ? remain_r : 16'h0000;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 16'h0000;
			mem_rdata_r <= 8'h00;
			panel_wdata_r <= 16'h0000;
			panel_sel_r <= 1'b0;
			panel_wr_r <= 1'b0;
			panel_rs_r <= 1'b0;
		end else begin
			if (reg_req.sel && !reg_req.wr) begin
				reg_rdata_r <= reg_rd;
			end
			if (mem_req.sel && !mem_req.wr) begin
				mem_rdata_r <= buf_r[mem_req.addr];
			end
			panel_wdata_r <= panel_bypass ? port_data_in : 16'h0000;
			panel_sel_r <= panel_bypass && port_cs;
			panel_wr_r <= panel_bypass && port_wr;
			panel_rs_r <= panel_bypass && port_addr[0];
		end
	end

	assign port_data_out = data_out_r;
	assign port_data_oe_n = oe_n_r;
	assign port_irq = ctrl_r[host_port_pkg::CTL_DEV_IRQ];
	assign modem_irq = ctrl_r[host_port_pkg::CTL_MODEM_IRQ];
	assign reg_rdata = reg_rdata_r;
	assign mem_rdata = mem_rdata_r;
	assign panel_wdata = panel_wdata_r;
	assign panel_sel = panel_sel_r;
	assign panel_wr = panel_wr_r;
	assign panel_reg_select = panel_rs_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	dev_irq_write_a: assert property (c_ctrl_wr |=> port_irq == $past(reg_req.wdata[4]))
		else $error("device interrupt bit did not follow processor write");
	modem_irq_write_a: assert property (m_ctrl_wr |=> modem_irq == $past(port_data_in[5]))
		else $error("modem interrupt bit did not follow modem write");
	modem_irq_guard_a: assert property (!m_ctrl_wr |=> $stable(modem_irq))
		else $error("modem interrupt bit changed without a modem write");
	burst_load_a: assert property (acc_burst && armed_r |=>
		live_ofs_r == 16'($past(start_init_r) + $past(step)))
		else $error("burst did not start from the initial offset");
	remain_drop_a: assert property (acc_burst |=>
		remain_r == 16'h0000 || remain_r == 16'($past(cnt_use) - $past(step)))
		else $error("remaining count did not drop by the bytes moved");
	single_hold_a: assert property (wr_take && port_addr == host_port_pkg::TGT_SINGLE
		|=> $stable(live_ofs_r) && $stable(remain_r))
		else $error("single access moved the live registers");
	read_drive_a: assert property (rd_start ##1 rd_go |=> !port_data_oe_n)
		else $error("read strobe did not drive the data bus");
	disabled_quiet_a: assert property (!port_live ##1 !port_live |-> port_data_oe_n)
		else $error("disabled port drove the data bus");
	bypass_map_a: assert property (panel_bypass |=> panel_reg_select == $past(port_addr[0]))
		else $error("bypass did not carry address bit 0 to the panel");
	write_width_a: assert property (wr_take |-> wr_act && $past(wr_act, WR_TAKE_CYC - 1))
		else $error("write taken before the strobe was held two clocks");
endmodule

// ---- logic/host_port_pkg.sv ----
package host_port_pkg;
	// ---------------------------------------------------------------
	// Register offsets on the processor side
	// ---------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_LEN_INIT = 5'h04;
	localparam logic [4:0] OFS_START_INIT = 5'h08;
	localparam logic [4:0] OFS_LIVE_OFS = 5'h0c;
	localparam logic [4:0] OFS_REMAIN = 5'h10;
	// ---------------------------------------------------------------
	// Control register fields and reset values
	// ---------------------------------------------------------------
	localparam int CTL_MODEM_IRQ = 5;
	localparam int CTL_DEV_IRQ = 4;
	localparam int CTL_POLARITY = 3;
	localparam int CTL_LIVE_SEL = 2;
	localparam int CTL_CNT_HI = 1;
	localparam int CTL_OFS_HI = 0;
	localparam logic [7:0] CTRL_MODEM_MASK = 8'h27;
	localparam logic [7:0] CTRL_CPU_MASK = 8'h1c;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] INIT_RESET = 16'h0000;
	// ---------------------------------------------------------------
	// Sizes and timing
	// ---------------------------------------------------------------
	localparam int BUF_BYTES = 2048;
	localparam int FIFO_DEPTH = 32;
	localparam int WR_TAKE_CYC = 2;
	localparam logic [15:0] STEP_NARROW = 16'h0001;
	localparam logic [15:0] STEP_WIDE = 16'h0002;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TGT_CTRL = 2'b00,
		TGT_INIT = 2'b01,
		TGT_SINGLE = 2'b10,
		TGT_BURST = 2'b11
	} port_target_t;
	typedef struct packed {
		logic [10:0] offset;
		logic [15:0] data;
		logic wide;
	} buf_wr_t;
	typedef struct packed {
		logic sel;
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic sel;
		logic wr;
		logic [10:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
endpackage

// ---- logic/stream_fifo.sv ----
`timescale 1ns/1ns
module stream_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("stream_fifo needs a power-of-two depth of at least two");
	end

	logic [WIDTH-1:0] store_r [0:DEPTH-1];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = store_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			store_r[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
		end
	end
endmodule

// ---- tb/modem_model.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Modem side of the host port
// ---------------------------------------------------------------
// Strobes are kept as active flags and turned into pin levels by the polarity, so a
// polarity change never needs a separate idle update.
module modem_model (
	input wire logic ref_clk,
	input wire logic pol,
	input wire logic [15:0] port_data_out,
	input wire logic port_data_oe_n,
	output logic port_cs,
	output logic port_rd,
	output logic port_wr,
	output logic [1:0] port_addr,
	output logic [15:0] port_data_in
);
	logic cs_on = 1'b0;
	logic rd_on = 1'b0;
	logic wr_on = 1'b0;
	assign port_cs = cs_on ~^ pol;
	assign port_rd = rd_on ~^ pol;
	assign port_wr = wr_on ~^ pol;
	initial begin
		port_addr = 2'h0;
		port_data_in = 16'hffff;
	end
	task automatic tick();
		@(posedge ref_clk);
		#5;
	endtask
	// Released data shows the inverse of the last word so a stale value never matches.
	task automatic write(input logic [1:0] a, input logic [15:0] d);
		tick();
		cs_on = 1'b1;
		wr_on = 1'b1;
		port_addr = a;
		port_data_in = d;
		repeat (3) tick();
		wr_on = 1'b0;
		tick();
		cs_on = 1'b0;
		port_data_in = ~d;
		repeat (3) tick();
	endtask
	task automatic read(input logic [1:0] a, output logic [15:0] d, output logic oe_n);
		tick();
		cs_on = 1'b1;
		rd_on = 1'b1;
		port_addr = a;
		repeat (3) tick();
		d = port_data_out;
		oe_n = port_data_oe_n;
		rd_on = 1'b0;
		tick();
		cs_on = 1'b0;
		repeat (3) tick();
	endtask
endmodule

// ---- tb/modem_host_port_buffer_test.sv ----
`timescale 1ns/1ns
module modem_host_port_buffer_test;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic port_enable = 1'b1;
	logic panel_bypass = 1'b0;
	logic wide_bus = 1'b0;
	logic pol = 1'b0;
	logic port_cs, port_rd, port_wr, port_data_oe_n, port_irq, port_wait, modem_irq;
	logic [1:0] port_addr;
	logic [15:0] port_data_in, port_data_out, reg_rdata, panel_wdata, rd;
	logic panel_sel, panel_wr, panel_reg_select, oe;
	logic [7:0] mem_rdata, b;
	host_port_pkg::reg_req_t reg_req = '0;
	host_port_pkg::mem_req_t mem_req = '0;
	int failures = 0;
	int cmp_count = 0;
	int n;
	logic [7:0] ctl_tab [4] = '{8'h24, 8'h26, 8'h21, 8'h20};
	logic [7:0] exp_tab [4] = '{8'h02, 8'h01, 8'h01, 8'h13};
	always #50 ref_clk = ~ref_clk;
	modem_host_port_buffer modem_host_port_buffer_inst (.ref_clk(ref_clk), .resetn(resetn),
		.port_enable(port_enable), .panel_bypass(panel_bypass), .wide_bus(wide_bus),
		.port_cs(port_cs), .port_rd(port_rd), .port_wr(port_wr), .port_addr(port_addr),
		.port_data_in(port_data_in), .port_data_out(port_data_out),
		.port_data_oe_n(port_data_oe_n), .port_irq(port_irq), .port_wait(port_wait),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.modem_irq(modem_irq), .panel_wdata(panel_wdata), .panel_sel(panel_sel),
		.panel_wr(panel_wr), .panel_reg_select(panel_reg_select));
	modem_model modem_model_inst (.ref_clk(ref_clk), .pol(pol), .port_data_out(port_data_out),
		.port_data_oe_n(port_data_oe_n), .port_cs(port_cs), .port_rd(port_rd),
		.port_wr(port_wr), .port_addr(port_addr), .port_data_in(port_data_in));
	// ---------------------------------------------------------------
	// Processor-side access and checking
	// ---------------------------------------------------------------
	task automatic tick();
		@(posedge ref_clk);
		#5;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cpu_wr(input logic [4:0] a, input logic [15:0] d);
		tick();
		reg_req = '{1'b1, 1'b1, a, d};
		tick();
		reg_req.sel = 1'b0;
	endtask
	task automatic cpu_rd(input logic [4:0] a, output logic [15:0] d);
		tick();
		reg_req = '{1'b1, 1'b0, a, 16'h0000};
		tick();
		reg_req.sel = 1'b0;
		d = reg_rdata;
	endtask
	task automatic mem_wr(input logic [10:0] a, input logic [7:0] d);
		tick();
		mem_req = '{1'b1, 1'b1, a, d};
		tick();
		mem_req.sel = 1'b0;
	endtask
	task automatic mem_rd(input logic [10:0] a, output logic [7:0] d);
		tick();
		mem_req = '{1'b1, 1'b0, a, 8'h00};
		tick();
		mem_req.sel = 1'b0;
		d = mem_rdata;
	endtask
	task automatic conclude();
		$display("compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		#5000000;
		failures++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		#5;
		resetn = 1'b1;
		repeat (4) tick();
		for (int i = 0; i < 6; i++) begin
			cpu_rd(5'(i * 4), rd);
			check(rd, 16'h0000);
		end
		check(panel_wdata, 16'h0000);
		$display("test reset values done");
		cpu_wr(host_port_pkg::OFS_LEN_INIT, 16'h0105);
		cpu_wr(host_port_pkg::OFS_START_INIT, 16'h0110);
		cpu_wr(host_port_pkg::OFS_LIVE_OFS, 16'hbeef);
		cpu_rd(host_port_pkg::OFS_LEN_INIT, rd);
		check(rd, 16'h0105);
		cpu_rd(host_port_pkg::OFS_START_INIT, rd);
		check(rd, 16'h0110);
		cpu_rd(host_port_pkg::OFS_LIVE_OFS, rd);
		check(rd, 16'h0000);
		$display("test init registers done");
		for (int i = 0; i < 3; i++) modem_model_inst.write(2'b11, {8'h00, 8'ha1 + 8'(i)});
		cpu_rd(host_port_pkg::OFS_LIVE_OFS, rd);
		check(rd, 16'h0113);
		cpu_rd(host_port_pkg::OFS_REMAIN, rd);
		check(rd, 16'h0102);
		n = 0;
		do begin
			mem_rd(11'h112, b);
			n++;
		end while (b !== 8'ha3 && n < 20);
		if (n >= 20) begin
			failures++;
			conclude();
		end
		for (int i = 0; i < 3; i++) begin
			mem_rd(11'h110 + 11'(i), b);
			check({8'h00, b}, {8'h00, 8'ha1 + 8'(i)});
		end
		$display("test burst write done");
		mem_wr(11'h113, 8'h5c);
		modem_model_inst.read(2'b10, rd, oe);
		check(rd, 16'h005c);
		check({15'h0000, oe}, 16'h0000);
		cpu_rd(host_port_pkg::OFS_LIVE_OFS, rd);
		check(rd, 16'h0113);
		wide_bus = 1'b1;
		modem_model_inst.read(2'b10, rd, oe);
		check(rd, 16'h5ca3);
		wide_bus = 1'b0;
		modem_model_inst.write(2'b10, 16'h0077);
		mem_rd(11'h113, b);
		check({8'h00, b}, 16'h0077);
		check({15'h0000, port_wait}, 16'h0000);
		$display("test single read done");
		modem_model_inst.write(2'b00, 16'h0020);
		check({15'h0000, modem_irq}, 16'h0001);
		cpu_wr(host_port_pkg::OFS_CTRL, 16'h0014);
		cpu_rd(host_port_pkg::OFS_CTRL, rd);
		check(rd, 16'h0034);
		check({15'h0000, port_irq}, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			modem_model_inst.write(2'b00, {8'h00, ctl_tab[i]});
			modem_model_inst.read(2'b01, rd, oe);
			check(rd, {8'h00, exp_tab[i]});
		end
		modem_model_inst.read(2'b11, rd, oe);
		check(rd, 16'h0077);
		cpu_rd(host_port_pkg::OFS_LIVE_OFS, rd);
		check(rd, 16'h0114);
		cpu_rd(host_port_pkg::OFS_REMAIN, rd);
		check(rd, 16'h0101);
		modem_model_inst.write(2'b00, 16'h0004);
		modem_model_inst.write(2'b01, 16'h0033);
		cpu_rd(host_port_pkg::OFS_LEN_INIT, rd);
		check(rd, 16'h0133);
		wide_bus = 1'b1;
		modem_model_inst.write(2'b11, 16'hbeef);
		wide_bus = 1'b0;
		mem_rd(11'h111, b);
		check({8'h00, b}, 16'h00be);
		cpu_rd(host_port_pkg::OFS_LIVE_OFS, rd);
		check(rd, 16'h0112);
		modem_model_inst.write(2'b00, 16'h0000);
		check({15'h0000, modem_irq}, 16'h0000);
		$display("test control done");
		port_enable = 1'b0;
		modem_model_inst.write(2'b00, 16'h0020);
		cpu_rd(host_port_pkg::OFS_CTRL, rd);
		check(rd, 16'h0010);
		mem_wr(11'h7ff, 8'h9e);
		mem_rd(11'h7ff, b);
		check({8'h00, b}, 16'h009e);
		cpu_wr(host_port_pkg::OFS_CTRL, 16'h0018);
		pol = 1'b1;
		tick();
		port_enable = 1'b1;
		modem_model_inst.read(2'b00, rd, oe);
		check(rd, 16'h0018);
		$display("test disable and polarity done");
		panel_bypass = 1'b1;
		fork
			modem_model_inst.write(2'b01, 16'h1234);
			begin
				repeat (3) tick();
				check(panel_wdata, 16'h1234);
				check({13'h0000, panel_sel, panel_wr, panel_reg_select}, 16'h0007);
			end
		join
		cpu_rd(host_port_pkg::OFS_LEN_INIT, rd);
		check(rd, 16'h0133);
		$display("test bypass done");
		conclude();
	end
endmodule
